/* design/cpu_core_pkg.sv */
package cpu_core_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W = 16;
    localparam int PC_W = 23;
    localparam int PC_HI_W = PC_W - 16;
    localparam int NUM_GP = 15;
    localparam int NUM_SHADOW_W = 4;
    localparam int LOOP_CNT_W = 16;
    localparam int TAG_W = 8;

    // ==========================================================
    // Reset values and stack constants
    localparam logic [15:0] SP_RESET_ADDR = 16'h0800;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] WREG_RESET = 16'h0000;
    localparam logic [15:0] SP_STEP = 16'h0002;
    localparam logic [16:0] LIMIT_MARGIN = 17'h00002;
    localparam logic [15:0] WORD_ALIGN_MASK = 16'hfffe;
    localparam logic [3:0] SP_INDEX = 4'hf;

    // ==========================================================
    // Status word field positions
    localparam int SB_C = 0;
    localparam int SB_Z = 1;
    localparam int SB_OV = 2;
    localparam int SB_N = 3;
    localparam int SB_RA = 4;
    localparam int SB_DC = 8;
    localparam int SB_DA = 9;
    localparam int SB_CLIP_EITHER = 10;
    localparam int SB_OVF_EITHER = 11;
    localparam int SB_CLIP_B = 12;
    localparam int SB_CLIP_A = 13;
    localparam int SB_OVF_B = 14;
    localparam int SB_OVF_A = 15;

    // Bits software may write freely, and bits it may only clear
    localparam logic [15:0] STATUS_SW_RW_MASK = 16'h01ef;
    localparam logic [15:0] STATUS_SW_CLR_MASK = 16'h3400;

    // ==========================================================
    // Stack sequencer
    typedef enum logic [0:0] {
        STK_IDLE = 1'b0,
        STK_PC_HI = 1'b1
    } stack_state_type;

endpackage

/* design/loop_shadow.sv */
`timescale 1ns/1ps
`default_nettype none

module loop_shadow
    import cpu_core_pkg::*;
#(
    parameter int AW = PC_W,
    parameter int CW = LOOP_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Loop sequencer events
    input wire logic do_exec,
    input wire logic do_exit,
    input wire logic [AW-1:0] new_first_addr,
    input wire logic [AW-1:0] new_last_addr,
    input wire logic [CW-1:0] new_iter_count,
    // Active loop registers
    output logic [AW-1:0] loop_first_addr,
    output logic [AW-1:0] loop_last_addr,
    output logic [CW-1:0] loop_iter_count,
    output logic loop_active
);

    logic [AW-1:0] sh_first_reg;
    logic [AW-1:0] sh_last_reg;
    logic [CW-1:0] sh_count_reg;
    logic [1:0] depth_reg;

    // ==========================================================
    // One-level shadow: a third nested loop overwrites the outer copy,
    // so software must save the loop registers beyond two levels
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loop_first_addr <= '0;
            loop_last_addr <= '0;
            loop_iter_count <= '0;
            sh_first_reg <= '0;
            sh_last_reg <= '0;
            sh_count_reg <= '0;
            depth_reg <= 2'h0;
            loop_active <= 1'b0;
        end else if (do_exec) begin
            sh_first_reg <= loop_first_addr;
            sh_last_reg <= loop_last_addr;
            sh_count_reg <= loop_iter_count;
            loop_first_addr <= new_first_addr;
            loop_last_addr <= new_last_addr;
            loop_iter_count <= new_iter_count;
            depth_reg <= (depth_reg == 2'h2) ? 2'h2 : depth_reg + 2'h1;
            loop_active <= 1'b1;
        end else if (do_exit && depth_reg != 2'h0) begin
            loop_first_addr <= sh_first_reg;
            loop_last_addr <= sh_last_reg;
            loop_iter_count <= sh_count_reg;
            depth_reg <= depth_reg - 2'h1;
            loop_active <= (depth_reg != 2'h1);
        end
    end

endmodule

`default_nettype wire

/* design/cpu_stack_shadow_regs.sv */
// How it works
// - Shadow save copies W0-W3 and flags N, OV, Z, C, half carry.
// - Shadow restore loads W0-W3 and those five flags back.
// - Shadow store is one level; each save overwrites the last.
// - No port reads or writes any shadow copy directly.
// - Each loop start copies loop first, last and count into a shadow.
// - One-level loop shadow allows exactly two nested loops.
// - Reset clears W0-W14 and marks them uninitialized.
// - Using an uninitialized register as pointer requests device reset.
// - Word writes and shadow restore (W0-W3) clear the uninitialized mark; byte writes do not.
// - Stack pointer bit zero is always zero.
// - Reset loads the stack pointer with 0x0800.
// - Stack grows upward; push writes then adds two, pop subtracts then reads.
// - Stacked PC: low 16 bits first word, upper bits next word.
// - Call stacking puts zero in upper byte of second PC word.
// - Exception stacking puts status low byte in that upper byte.
// - Stack limit is 16 bits, resets to zero, bit zero fixed zero.
// - Overflow check starts at first limit word write; only reset stops it.
// - Checked stack addresses above limit plus two raise stack error.
// - Check covers every stack-pointer address, calls and interrupts included.
// - With checking on, address wrap past 0xFFFF raises stack error.
// - Stack address below 0x0800 always raises stack error.
// - Loop, repeat and accumulator overflow flags are hardware-only.
// - Clip stickies set by hardware, cleared by software; either clears all.
`timescale 1ns/1ps
`default_nettype none

module cpu_stack_shadow_regs
    import cpu_core_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Working register write and read
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic wr_word,
    input wire logic wr_hi,
    input wire logic [15:0] wr_data,
    input wire logic [3:0] rd_idx,
    output logic [15:0] rd_data,
    // Pointer use check
    input wire logic ptr_use,
    input wire logic [3:0] ptr_idx,
    output logic uninit_reset,
    // Context shadow
    input wire logic shadow_save,
    input wire logic shadow_restore,
    // Status word sources and software access
    input wire logic alu_flags_we,
    input wire logic [4:0] alu_flags,
    input wire logic acc_a_ovf_in,
    input wire logic acc_b_ovf_in,
    input wire logic acc_a_clip_set,
    input wire logic acc_b_clip_set,
    input wire logic repeat_active_in,
    input wire logic status_wr_en,
    input wire logic [1:0] status_wr_mask,
    input wire logic [15:0] status_wr_data,
    output logic [15:0] cpu_status_word,
    // Hardware loop
    input wire logic do_exec,
    input wire logic do_exit,
    input wire logic [PC_W-1:0] do_first_addr,
    input wire logic [PC_W-1:0] do_last_addr,
    input wire logic [LOOP_CNT_W-1:0] do_iter_count,
    output logic [PC_W-1:0] loop_first_addr,
    output logic [PC_W-1:0] loop_last_addr,
    output logic [LOOP_CNT_W-1:0] loop_iter_count,
    // Stack limit
    input wire logic limit_wr_en,
    input wire logic limit_word,
    input wire logic limit_hi,
    input wire logic [15:0] limit_wr_data,
    output logic [15:0] stack_limit,
    // Stack operations
    input wire logic push_en,
    input wire logic [15:0] push_data,
    input wire logic pop_en,
    input wire logic pc_push_en,
    input wire logic pc_push_exc,
    input wire logic [PC_W-1:0] pc_value,
    input wire logic sp_ea_en,
    input wire logic [15:0] sp_ea,
    input wire logic sp_ea_wrap,
    input wire logic [TAG_W-1:0] instr_tag,
    // Stack memory side and errors
    output logic mem_wr_en,
    output logic mem_rd_en,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wr_data,
    output logic stack_busy,
    output logic stack_err,
    output logic [TAG_W-1:0] stack_err_tag
);

    // ==========================================================
    // Storage
    logic [15:0] wreg_reg [NUM_GP];
    logic uninit_reg [NUM_GP];
    logic [15:0] sp_reg;
    logic [15:0] shadow_w_reg [NUM_SHADOW_W];
    logic [4:0] shadow_flag_reg;
    logic [15:0] status_next;
    logic chk_en_reg;
    stack_state_type stk_state;
    logic [15:0] pc_hi_reg;
    logic [TAG_W-1:0] pc_tag_reg;
    logic loop_active;
    logic [16:0] sp_plus;
    logic [16:0] sp_minus;
    logic [16:0] chk_ea;
    logic chk_act;
    logic chk_pop;
    logic err_now;
    logic [16:0] lim_plus;

    // ==========================================================
    // Working registers W0-W14
    genvar g;
    generate
        for (g = 0; g < NUM_GP; g++) begin : gp
            localparam int unsigned SI = g % NUM_SHADOW_W;
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    wreg_reg[g] <= WREG_RESET;
                    uninit_reg[g] <= 1'b1;
                end else if (shadow_restore && g < NUM_SHADOW_W) begin
                    wreg_reg[g] <= shadow_w_reg[SI];
                    uninit_reg[g] <= 1'b0;
                end else if (wr_en && wr_idx == 4'(g)) begin
                    if (wr_word) begin
                        wreg_reg[g] <= wr_data;
                        uninit_reg[g] <= 1'b0;
                    end else if (wr_hi) begin
                        wreg_reg[g][15:8] <= wr_data[7:0];
                    end else begin
                        wreg_reg[g][7:0] <= wr_data[7:0];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= WREG_RESET;
        end else begin
            rd_data <= (rd_idx == SP_INDEX) ? sp_reg : wreg_reg[rd_idx];
        end
    end

    // Pointer from a register never word-written or restored is fatal to the program
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            uninit_reset <= 1'b0;
        end else begin
            uninit_reset <= ptr_use && ptr_idx != SP_INDEX && uninit_reg[ptr_idx];
        end
    end

    // ==========================================================
    // Context shadow, no path out except restore
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_SHADOW_W; i++) begin
                shadow_w_reg[i] <= WREG_RESET;
            end
            shadow_flag_reg <= 5'h00;
        end else if (shadow_save) begin
            for (int i = 0; i < NUM_SHADOW_W; i++) begin
                shadow_w_reg[i] <= wreg_reg[i];
            end
            shadow_flag_reg <= {cpu_status_word[SB_DC], cpu_status_word[SB_N],
                                cpu_status_word[SB_OV], cpu_status_word[SB_Z],
                                cpu_status_word[SB_C]};
        end
    end

    // ==========================================================
    // Status word
    always_comb begin
        logic [15:0] lane;
        logic [15:0] clr;
        lane = {{8{status_wr_mask[1]}}, {8{status_wr_mask[0]}}};
        clr = 16'h0000;
        status_next = cpu_status_word;
        if (status_wr_en) begin
            status_next = (status_next & ~(STATUS_SW_RW_MASK & lane))
                        | (status_wr_data & STATUS_SW_RW_MASK & lane);
            clr = ~status_wr_data & STATUS_SW_CLR_MASK & lane;
            if (clr[SB_CLIP_EITHER]) begin
                clr = clr | STATUS_SW_CLR_MASK;
            end
            status_next = status_next & ~clr;
        end
        if (alu_flags_we) begin
            {status_next[SB_DC], status_next[SB_N], status_next[SB_OV],
             status_next[SB_Z], status_next[SB_C]} = alu_flags;
        end
        if (shadow_restore) begin
            {status_next[SB_DC], status_next[SB_N], status_next[SB_OV],
             status_next[SB_Z], status_next[SB_C]} = shadow_flag_reg;
        end
        status_next[SB_OVF_A] = acc_a_ovf_in;
        status_next[SB_OVF_B] = acc_b_ovf_in;
        status_next[SB_OVF_EITHER] = acc_a_ovf_in | acc_b_ovf_in;
        status_next[SB_DA] = loop_active;
        status_next[SB_RA] = repeat_active_in;
        // A set arriving with a software clear survives it
        if (acc_a_clip_set) begin
            status_next[SB_CLIP_A] = 1'b1;
        end
        if (acc_b_clip_set) begin
            status_next[SB_CLIP_B] = 1'b1;
        end
        if (acc_a_clip_set || acc_b_clip_set) begin
            status_next[SB_CLIP_EITHER] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_status_word <= STATUS_RESET;
        end else begin
            cpu_status_word <= status_next;
        end
    end

    // ==========================================================
    // Hardware loop shadow
    loop_shadow #(
        .AW(PC_W),
        .CW(LOOP_CNT_W)
    ) u_loop_shadow (
        .clk(clk),
        .sys_rst(sys_rst),
        .do_exec(do_exec),
        .do_exit(do_exit),
        .new_first_addr(do_first_addr),
        .new_last_addr(do_last_addr),
        .new_iter_count(do_iter_count),
        .loop_first_addr(loop_first_addr),
        .loop_last_addr(loop_last_addr),
        .loop_iter_count(loop_iter_count),
        .loop_active(loop_active)
    );

    // ==========================================================
    // Stack limit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stack_limit <= LIMIT_RESET;
            chk_en_reg <= 1'b0;
        end else if (limit_wr_en) begin
            if (limit_word) begin
                stack_limit <= limit_wr_data & WORD_ALIGN_MASK;
                chk_en_reg <= 1'b1;
            end else if (limit_hi) begin
                stack_limit[15:8] <= limit_wr_data[7:0];
            end else begin
                stack_limit[7:0] <= limit_wr_data[7:0] & WORD_ALIGN_MASK[7:0];
            end
        end
    end

    // ==========================================================
    // Stack address checks
    assign sp_plus = {1'b0, sp_reg} + {1'b0, SP_STEP};
    assign sp_minus = {1'b0, sp_reg} - {1'b0, SP_STEP};
    assign lim_plus = {1'b0, stack_limit} + LIMIT_MARGIN;

    always_comb begin
        chk_act = 1'b0;
        chk_pop = 1'b0;
        chk_ea = 17'h00000;
        unique case (stk_state)
            STK_IDLE: begin
                if (pc_push_en || push_en) begin
                    chk_act = 1'b1;
                    chk_ea = {sp_plus[16], sp_reg};
                end else if (pop_en) begin
                    chk_act = 1'b1;
                    chk_pop = 1'b1;
                    chk_ea = sp_minus;
                end else if (sp_ea_en) begin
                    chk_act = 1'b1;
                    chk_ea = {sp_ea_wrap, sp_ea};
                end
            end
            STK_PC_HI: begin
                chk_act = 1'b1;
                chk_ea = {sp_plus[16], sp_reg};
            end
        endcase
        err_now = chk_act && ((chk_en_reg && chk_ea[16])
                  || chk_ea[15:0] < SP_RESET_ADDR || (chk_pop && chk_ea[16])
                  || (chk_en_reg && {1'b0, chk_ea[15:0]} > lim_plus));
    end

    // ==========================================================
    // Stack pointer and sequencer; stack moves beat explicit writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sp_reg <= SP_RESET_ADDR;
            stk_state <= STK_IDLE;
            pc_hi_reg <= 16'h0000;
            pc_tag_reg <= '0;
            stack_busy <= 1'b0;
            mem_wr_en <= 1'b0;
            mem_rd_en <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wr_data <= 16'h0000;
        end else begin
            mem_wr_en <= 1'b0;
            mem_rd_en <= 1'b0;
            stack_busy <= 1'b0;
            unique case (stk_state)
                STK_IDLE: begin
                    if (pc_push_en) begin
                        mem_wr_en <= 1'b1;
                        mem_addr <= sp_reg;
                        mem_wr_data <= pc_value[15:0];
                        pc_hi_reg <= {pc_push_exc ? cpu_status_word[7:0] : 8'h00,
                                      {(8 - PC_HI_W){1'b0}}, pc_value[PC_W-1:16]};
                        pc_tag_reg <= instr_tag;
                        sp_reg <= sp_plus[15:0];
                        stk_state <= STK_PC_HI;
                        stack_busy <= 1'b1;
                    end else if (push_en) begin
                        mem_wr_en <= 1'b1;
                        mem_addr <= sp_reg;
                        mem_wr_data <= push_data;
                        sp_reg <= sp_plus[15:0];
                    end else if (pop_en) begin
                        mem_rd_en <= 1'b1;
                        mem_addr <= sp_minus[15:0];
                        sp_reg <= sp_minus[15:0];
                    end else if (wr_en && wr_idx == SP_INDEX) begin
                        if (wr_word) begin
                            sp_reg <= wr_data & WORD_ALIGN_MASK;
                        end else if (wr_hi) begin
                            sp_reg[15:8] <= wr_data[7:0];
                        end else begin
                            sp_reg[7:0] <= wr_data[7:0] & WORD_ALIGN_MASK[7:0];
                        end
                    end
                end
                STK_PC_HI: begin
                    mem_wr_en <= 1'b1;
                    mem_addr <= sp_reg;
                    mem_wr_data <= pc_hi_reg;
                    sp_reg <= sp_plus[15:0];
                    stk_state <= STK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stack_err <= 1'b0;
            stack_err_tag <= '0;
        end else begin
            stack_err <= err_now;
            stack_err_tag <= (stk_state == STK_PC_HI) ? pc_tag_reg : instr_tag;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence pc_req_s;
        stk_state == STK_IDLE && pc_push_en;
    endsequence

    sequence pc_lo_word_s;
        mem_wr_en && mem_addr == $past(sp_reg);
    endsequence

    sequence pc_hi_word_s;
        mem_wr_en && mem_addr == $past(mem_addr) + SP_STEP;
    endsequence

    shadow_save_copy_a: assert property (shadow_save |=> shadow_w_reg[3] == $past(wreg_reg[3]))
        else $error("shadow save missed W3");
    shadow_restore_load_a: assert property (shadow_restore |=>
        wreg_reg[0] == $past(shadow_w_reg[0]) && cpu_status_word[SB_C] == $past(shadow_flag_reg[0]))
        else $error("shadow restore mismatch");
    uninit_ptr_reset_a: assert property (ptr_use && ptr_idx != SP_INDEX
        && uninit_reg[ptr_idx] |=> uninit_reset)
        else $error("uninitialized pointer not caught");
    sp_word_align_a: assert property (sp_reg[0] == 1'b0)
        else $error("stack pointer odd");
    sp_reset_value_a: assert property ($fell(sys_rst) |-> sp_reg == SP_RESET_ADDR)
        else $error("stack pointer reset value wrong");
    push_post_inc_a: assert property (stk_state == STK_IDLE && push_en && !pc_push_en |=>
        mem_wr_en && mem_addr == $past(sp_reg) && sp_reg == $past(sp_reg) + SP_STEP)
        else $error("push order wrong");
    pop_pre_dec_a: assert property (stk_state == STK_IDLE && pop_en && !push_en && !pc_push_en
        |=> mem_rd_en && mem_addr == sp_reg)
        else $error("pop order wrong");
    pc_two_words_a: assert property (pc_req_s |-> ##1 pc_lo_word_s ##1 pc_hi_word_s)
        else $error("program counter words misplaced");
    call_zero_fill_a: assert property (pc_req_s and !pc_push_exc |-> ##2 mem_wr_data[15:8] == 8'h00)
        else $error("call upper byte not zero");
    exc_status_byte_a: assert property (pc_req_s and pc_push_exc |->
        ##2 mem_wr_data[15:8] == $past(cpu_status_word[7:0], 2))
        else $error("exception upper byte wrong");
    limit_check_on_a: assert property (limit_wr_en && limit_word |=> chk_en_reg [*3])
        else $error("overflow check not latched on");
    underflow_trap_a: assert property (stk_state == STK_IDLE && pop_en && !push_en && !pc_push_en
        && sp_reg < SP_RESET_ADDR + SP_STEP |=> stack_err)
        else $error("underflow not trapped");
    clip_clear_all_a: assert property (status_wr_en && status_wr_mask[1]
        && !status_wr_data[SB_CLIP_EITHER] && !acc_a_clip_set && !acc_b_clip_set
        |=> cpu_status_word[SB_CLIP_A:SB_CLIP_B] == 2'b00 && !cpu_status_word[SB_CLIP_EITHER])
        else $error("clip stickies not cleared");

endmodule

`default_nettype wire

/* tb/stack_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module stack_mem_model (
    // Clock
    input wire logic clk,
    // Stack memory port
    input wire logic mem_wr_en,
    input wire logic mem_rd_en,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wr_data,
    output logic [15:0] rd_word
);
    logic [15:0] m [0:32767];

    always @(posedge clk) begin
        if (mem_wr_en) begin
            m[mem_addr[15:1]] <= mem_wr_data;
        end
    end

    // Inverse outside a read, so a stale word never passes for fresh data
    assign rd_word = mem_rd_en ? m[mem_addr[15:1]] : ~m[mem_addr[15:1]];
endmodule

`default_nettype wire

/* tb/test_cpu_stack_shadow_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end

module test_cpu_stack_shadow_regs;
    import cpu_core_pkg::*;
    // ====
    // Stimulus and observed signals
    logic clk = '0, sys_rst = '1, wr_en = '0, wr_word = '0, wr_hi = '0, ptr_use = '0;
    logic shadow_save = '0, shadow_restore = '0, alu_flags_we = '0, acc_a_ovf_in = '0;
    logic acc_b_ovf_in = '0, acc_a_clip_set = '0, acc_b_clip_set = '0, repeat_active_in = '0;
    logic status_wr_en = '0, do_exec = '0, do_exit = '0, limit_wr_en = '0, limit_word = '0;
    logic limit_hi = '0, push_en = '0, pop_en = '0, pc_push_en = '0, pc_push_exc = '0;
    logic sp_ea_en = '0, sp_ea_wrap = '0;
    logic [3:0] wr_idx = '0, rd_idx = '0, ptr_idx = '0;
    logic [15:0] wr_data = '0, status_wr_data = '0, limit_wr_data = '0, push_data = '0;
    logic [15:0] sp_ea = '0;
    logic [4:0] alu_flags = '0;
    logic [1:0] status_wr_mask = '0;
    logic [PC_W-1:0] do_first_addr = '0, do_last_addr = '0, pc_value = 23'h7abcde;
    logic [LOOP_CNT_W-1:0] do_iter_count = '0;
    logic [TAG_W-1:0] instr_tag = 8'h5c;
    logic [15:0] rd_data, cpu_status_word, stack_limit, mem_addr, mem_wr_data, rd_word;
    logic [PC_W-1:0] loop_first_addr, loop_last_addr;
    logic [LOOP_CNT_W-1:0] loop_iter_count;
    logic uninit_reset, mem_wr_en, mem_rd_en, stack_busy, stack_err;
    logic [TAG_W-1:0] stack_err_tag;
    int errors = 0, n_tests = 0, cyc = 0;

    cpu_stack_shadow_regs dut (.*);
    stack_mem_model mem (.clk, .mem_wr_en, .mem_rd_en, .mem_addr, .mem_wr_data, .rd_word);

    initial forever #4 clk = ~clk;

    // The whole run needs under a hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            give_verdict();
        end
    end

    // ====
    // Shared drivers
    task automatic tick(int n = 1);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic wr_reg(logic [3:0] i, logic [15:0] d, logic w);
        wr_idx = i;
        wr_data = d;
        wr_word = w;
        pulse(wr_en);
    endtask
    task automatic chk_reg(logic [3:0] i, logic [15:0] e);
        rd_idx = i;
        tick(2);
        `CHK("rd_data", e, rd_data)
    endtask
    task automatic ptr_chk(logic [3:0] i, logic e);
        ptr_idx = i;
        pulse(ptr_use);
        `CHK("uninit_reset", e, uninit_reset)
    endtask
    task automatic push(logic [15:0] d);
        push_data = d;
        pulse(push_en);
    endtask
    task automatic pc_push(logic exc, logic [15:0] a, logic [15:0] hi);
        pc_push_exc = exc;
        pulse(pc_push_en);
        `CHK("pc lo", {a, 16'hbcde}, {mem_addr, mem_wr_data})
        `CHK("busy", 1'b1, stack_busy)
        tick();
        `CHK("pc hi", {a + 16'h0002, hi}, {mem_addr, mem_wr_data})
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ====
    // Main sequence
    initial begin
        tick(16);
        sys_rst = 1'b0;
        tick();
        `CHK("limit", 16'h0000, stack_limit)
        chk_reg(4'hf, 16'h0800);
        chk_reg(4'h2, 16'h0000);
        $display("reset test end");
        push(16'h5a5a);
        `CHK("push", {2'b10, 32'h08005a5a}, {mem_wr_en, stack_err, mem_addr, mem_wr_data})
        push(16'h3636);
        pulse(pop_en);
        `CHK("pop", {1'b1, 32'h08023636}, {mem_rd_en, mem_addr, rd_word})
        chk_reg(4'hf, 16'h0802);
        $display("stack test end");
        status_wr_mask = 2'b01;
        status_wr_data = 16'h00a5;
        pulse(status_wr_en);
        pc_push(1'b1, 16'h0802, 16'ha57a);
        pc_push(1'b0, 16'h0806, 16'h007a);
        $display("pc test end");
        ptr_chk(4'h3, 1'b1);
        wr_reg(4'h3, 16'h00ab, 1'b0);
        ptr_chk(4'h3, 1'b1);
        wr_reg(4'h3, 16'h1234, 1'b1);
        ptr_chk(4'h3, 1'b0);
        $display("uninit test end");
        wr_reg(4'h0, 16'h1111, 1'b1);
        pulse(shadow_save);
        wr_reg(4'h0, 16'h2222, 1'b1);
        alu_flags = 5'h15;
        pulse(alu_flags_we);
        pulse(shadow_save);
        wr_reg(4'h0, 16'h3333, 1'b1);
        alu_flags = 5'h0a;
        pulse(alu_flags_we);
        pulse(shadow_restore);
        chk_reg(4'h0, 16'h2222);
        `CHK("flags", 16'h0105, cpu_status_word & 16'h010f)
        $display("shadow test end");
        do_first_addr = 23'h000100;
        do_iter_count = 16'h0003;
        pulse(do_exec);
        do_first_addr = 23'h000200;
        do_iter_count = 16'h0005;
        pulse(do_exec);
        `CHK("loop in", {23'h000200, 16'h0005}, {loop_first_addr, loop_iter_count})
        pulse(do_exit);
        `CHK("loop out", {23'h000100, 16'h0003}, {loop_first_addr, loop_iter_count})
        `CHK("loop active", 1'b1, cpu_status_word[9])
        pulse(do_exit);
        $display("loop test end");
        wr_reg(4'hf, 16'h0901, 1'b1);
        chk_reg(4'hf, 16'h0900);
        limit_word = 1'b1;
        limit_wr_data = 16'h08ff;
        pulse(limit_wr_en);
        `CHK("limit", 16'h08fe, stack_limit)
        push(16'h0001);
        `CHK("err edge", 1'b0, stack_err)
        push(16'h0002);
        `CHK("err", 9'h15c, {stack_err, stack_err_tag})
        tick();
        `CHK("err pulse", 1'b0, stack_err)
        wr_reg(4'hf, 16'h07fe, 1'b1);
        push(16'h0003);
        `CHK("underflow", 1'b1, stack_err)
        $display("limit test end");
        status_wr_mask = 2'b11;
        status_wr_data = 16'hffff;
        pulse(status_wr_en);
        tick();
        `CHK("status", 16'h01ef, cpu_status_word)
        pulse(acc_a_clip_set);
        tick();
        `CHK("clip", 1'b1, cpu_status_word[13])
        status_wr_mask = 2'b10;
        status_wr_data = 16'h3bff;
        pulse(status_wr_en);
        tick();
        `CHK("clip clr", 2'b00, {cpu_status_word[13], cpu_status_word[10]})
        $display("status test end");
        give_verdict();
    end
endmodule

`default_nettype wire
